// ---- logic/cmr_pkg.sv ----
// package for the count-mode core: modes, directions, limits
// assumes a single clock domain and 32-bit signed counting
package cmr_pkg;
    localparam int CNT_W = 32;
    typedef enum logic [1:0] {CMR_ENDLESS, CMR_ONE_TIME, CMR_PERIODIC} cmr_mode_t;
    typedef enum logic [1:0] {CMR_DIR_NONE, CMR_DIR_UP, CMR_DIR_DOWN} cmr_dir_t;
    localparam logic signed [CNT_W-1:0] CMR_UPPER = 32'sh7fffffff;
    localparam logic signed [CNT_W-1:0] CMR_LOWER = 32'sh80000000;
    localparam logic signed [CNT_W-1:0] CMR_ONE   = 32'sh00000001;
    localparam logic signed [CNT_W-1:0] CMR_ZERO  = 32'sh00000000;
endpackage : cmr_pkg

// ---- logic/cmr_core.sv ----
// count-mode core of a 32-bit signed up/down counter
// assumes count pulses and control edges are synchronous one-cycle inputs
// What this block does
// (R1) endless mode starts at load value, wraps upper to lower on up pulse
// (R2) endless mode wraps lower to upper on a further down pulse
// (R3) endless wrap sets overflow/underflow and alarm when alarms enabled
// (R4) status flags stay set until host pulses status clear
// (R5) one-time no direction: limit exceeded loads opposite limit, closes gate, flags
// (R6) host reopens gate; interrupt mode continues, cancel mode restarts at load
// (R7) one-time up: pulse after end minus one reloads, closes gate, end flag
// (R8) one-time with direction always restarts from load value after reopen
// (R9) one-time down: pulse after end plus one reloads, closes gate, end flag
// (R10) direction up: wrap lower to upper, underflow flag and alarm
// (R11) direction down: wrap upper to lower, overflow flag and alarm
// (R12) periodic no direction: at limit reload load value, flag, alarm
// (R13) periodic up: pulse after end minus one reloads, gate stays, end flag
// (R14) periodic down: pulse after end plus one reloads, gate stays, end flag
// (R15) host keeps end value above minimum for direction up
// (R16) host keeps end value below maximum for direction down
// (R17) gate opens on set edge, closes on clear edge, ANDed with hardware gate
// (R18) count limited to fixed signed 32-bit range
// (R19) two's complement value; pulses with gate closed leave value unchanged
`timescale 1ns/10ps
`default_nettype none
module cmr_core (
    // clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          rst_n_in,
    // encoder count pulses
    input  wire logic                          cnt_up_in,
    input  wire logic                          cnt_down_in,
    // configuration
    input  wire cmr_pkg::cmr_mode_t            mode_in,
    input  wire cmr_pkg::cmr_dir_t             dir_in,
    input  wire logic                          cancel_mode_in,
    input  wire logic                          alarm_en_in,
    input  wire logic                          hw_gate_en_in,
    input  wire logic                          hw_gate_in,
    input  wire logic signed [31:0]            load_value_in,
    input  wire logic signed [31:0]            end_value_in,
    // host control word bits
    input  wire logic                          gate_set_in,
    input  wire logic                          gate_clr_in,
    input  wire logic                          status_clr_in,
    // state and status
    output logic signed [31:0]                 count_out,
    output logic                               sw_gate_out,
    output logic                               overflow_out,
    output logic                               underflow_out,
    output logic                               end_reached_out,
    output logic                               alarm_req_out
);
    import cmr_pkg::*;

    logic              gate_set_d;
    logic              gate_clr_d;
    logic              restart_pend;
    logic              up_ev;
    logic              dn_ev;
    logic              int_gate;
    logic              set_edge;
    logic              clr_edge;
    logic signed [31:0] next_count;
    logic              ev_ovf;
    logic              ev_unf;
    logic              ev_end;
    logic              ev_close;

    assign set_edge = gate_set_in & ~gate_set_d; // R17
    assign clr_edge = gate_clr_in & ~gate_clr_d; // R17
    assign int_gate = sw_gate_out & (~hw_gate_en_in | hw_gate_in); // R17
    assign up_ev    = int_gate & cnt_up_in & ~cnt_down_in; // R19
    assign dn_ev    = int_gate & cnt_down_in & ~cnt_up_in; // R19

    always_comb begin
        next_count = count_out;
        ev_ovf     = 1'b0;
        ev_unf     = 1'b0;
        ev_end     = 1'b0;
        ev_close   = 1'b0;
        if (up_ev) begin
            if (dir_in == CMR_DIR_UP && mode_in != CMR_ENDLESS
                    && count_out == end_value_in - CMR_ONE) begin
                next_count = load_value_in; // R7 R13
                ev_end     = 1'b1;
                ev_close   = (mode_in == CMR_ONE_TIME); // R7
            end else if (count_out == CMR_UPPER) begin
                ev_ovf = 1'b1;
                if (mode_in == CMR_PERIODIC && dir_in == CMR_DIR_NONE) begin
                    next_count = load_value_in; // R12
                end else begin
                    next_count = CMR_LOWER; // R1 R5 R11 R18
                    ev_close   = (mode_in == CMR_ONE_TIME && dir_in == CMR_DIR_NONE); // R5
                end
            end else begin
                next_count = count_out + CMR_ONE; // R19
            end
        end else if (dn_ev) begin
            if (dir_in == CMR_DIR_DOWN && mode_in != CMR_ENDLESS
                    && count_out == end_value_in + CMR_ONE) begin
                next_count = load_value_in; // R9 R14
                ev_end     = 1'b1;
                ev_close   = (mode_in == CMR_ONE_TIME); // R9
            end else if (count_out == CMR_LOWER) begin
                ev_unf = 1'b1;
                if (mode_in == CMR_PERIODIC && dir_in == CMR_DIR_NONE) begin
                    next_count = load_value_in; // R12
                end else begin
                    next_count = CMR_UPPER; // R2 R5 R10 R18
                    ev_close   = (mode_in == CMR_ONE_TIME && dir_in == CMR_DIR_NONE); // R5
                end
            end else begin
                next_count = count_out - CMR_ONE; // R19
            end
        end
    end

    // control edge detectors
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gate_set_d <= 1'b0;
            gate_clr_d <= 1'b0;
        end else begin
            gate_set_d <= gate_set_in;
            gate_clr_d <= gate_clr_in;
        end
    end

    // software gate; auto-close and clear edge close it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_gate_out <= 1'b0;
        end else if (clr_edge || ev_close) begin
            sw_gate_out <= 1'b0; // R5 R7 R9 R17
        end else if (set_edge) begin
            sw_gate_out <= 1'b1; // R6 R17
        end
    end

    // restart from load value on gate open unless interrupt mode after a limit close or after a clear edge in endless or no-direction mode
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            restart_pend <= 1'b1;
        end else if (ev_close) begin
            restart_pend <= ev_end | cancel_mode_in; // R6 R8
        end else if (clr_edge) begin
            restart_pend <= cancel_mode_in | (mode_in != CMR_ENDLESS && dir_in != CMR_DIR_NONE);
        end else if (set_edge && !sw_gate_out) begin
            restart_pend <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= CMR_ZERO;
        end else if (set_edge && !clr_edge && !sw_gate_out
                && (restart_pend || cancel_mode_in)) begin
            // cancel mode is read at the open edge and also when the gate closed
            count_out <= load_value_in; // R1 R6 R8
        end else begin
            count_out <= next_count;
        end
    end

    // sticky status: set wins over clear
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overflow_out    <= 1'b0;
            underflow_out   <= 1'b0;
            end_reached_out <= 1'b0;
        end else begin
            overflow_out    <= ev_ovf | (overflow_out & ~status_clr_in); // R3 R4 R11
            underflow_out   <= ev_unf | (underflow_out & ~status_clr_in); // R3 R4 R10
            end_reached_out <= ev_end | (end_reached_out & ~status_clr_in); // R4
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alarm_req_out <= 1'b0;
        end else begin
            alarm_req_out <= alarm_en_in & (ev_ovf | ev_unf | ev_end); // R3 R12 R13 R14
        end
    end

    AST_GATE_CLOSE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R5
        (up_ev && mode_in == CMR_ONE_TIME && dir_in == CMR_DIR_NONE && count_out == CMR_UPPER)
        |=> (!sw_gate_out && count_out == CMR_LOWER && overflow_out))
        else $error("one-time overflow did not close gate");
    AST_ENDLESS_WRAP_UP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R1
        (up_ev && mode_in == CMR_ENDLESS && count_out == CMR_UPPER && !clr_edge)
        |=> (count_out == CMR_LOWER && sw_gate_out))
        else $error("endless up wrap wrong");
    AST_ENDLESS_WRAP_DN: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R2
        (dn_ev && mode_in == CMR_ENDLESS && count_out == CMR_LOWER && !set_edge)
        |=> (count_out == CMR_UPPER && underflow_out))
        else $error("endless down wrap wrong");
    AST_STICKY: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R4
        (overflow_out && !status_clr_in) |=> overflow_out)
        else $error("overflow flag dropped without clear");
    AST_ALARM: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R3
        alarm_req_out |-> $past(alarm_en_in))
        else $error("alarm without enable");
    AST_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R19
        (!int_gate && !set_edge) |=> $stable(count_out))
        else $error("count moved with gate closed");
    AST_END_UP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R13
        (up_ev && mode_in == CMR_PERIODIC && dir_in == CMR_DIR_UP
         && count_out == end_value_in - CMR_ONE && !clr_edge)
        |=> (sw_gate_out && end_reached_out))
        else $error("periodic up end handling wrong");
    AST_END_DN: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R9
        (dn_ev && mode_in == CMR_ONE_TIME && dir_in == CMR_DIR_DOWN
         && count_out == end_value_in + CMR_ONE)
        |=> (!sw_gate_out && end_reached_out))
        else $error("one-time down end handling wrong");

    // end-value step of a one-time up count
    sequence s_one_up_end;
        up_ev && mode_in == CMR_ONE_TIME && dir_in == CMR_DIR_UP
            && count_out == end_value_in - CMR_ONE;
    endsequence
    // down pulse at the lower limit with primary direction up
    sequence s_dir_up_unf;
        dn_ev && mode_in != CMR_ENDLESS && dir_in == CMR_DIR_UP && count_out == CMR_LOWER;
    endsequence

    AST_END_UP_ONCE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R7
        s_one_up_end
        |=> (!sw_gate_out && end_reached_out && count_out == $past(load_value_in)))
        else $error("one-time up end handling wrong");
    AST_DIR_UP_WRAP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R10
        s_dir_up_unf |=> (count_out == CMR_UPPER && underflow_out))
        else $error("direction up underflow wrap wrong");
    AST_PER_NONE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R12
        (up_ev && mode_in == CMR_PERIODIC && dir_in == CMR_DIR_NONE && count_out == CMR_UPPER)
        |=> (count_out == $past(load_value_in) && overflow_out))
        else $error("periodic limit reload wrong");
    AST_CANCEL_LOAD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R6
        (set_edge && !clr_edge && !sw_gate_out && cancel_mode_in)
        |=> (sw_gate_out && count_out == $past(load_value_in)))
        else $error("cancel mode open did not load");
    AST_ALARM_EV: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // R3
        (alarm_en_in && (ev_ovf || ev_unf || ev_end)) |=> alarm_req_out)
        else $error("enabled event raised no alarm");
endmodule : cmr_core
`default_nettype wire

// ---- dv/cmr_enc_model.sv ----
// encoder and host model: count pulses, host parameters and control word bits
// assumes everything is launched on the falling edge of the core clock
`timescale 1ns/10ps
`default_nettype none
module cmr_enc_model (
    // clock
    input  wire logic                        ref_clk_in,
    // count pulses
    output logic                             cnt_up_out,
    output logic                             cnt_down_out,
    // host parameters
    output var cmr_pkg::cmr_mode_t           mode_out,
    output var cmr_pkg::cmr_dir_t            dir_out,
    output logic                             cancel_mode_out,
    output logic                             alarm_en_out,
    output logic                             hw_gate_en_out,
    output logic                             hw_gate_out,
    output logic signed [cmr_pkg::CNT_W-1:0] load_value_out,
    output logic signed [cmr_pkg::CNT_W-1:0] end_value_out,
    // host control word bits
    output logic                             gate_set_out,
    output logic                             gate_clr_out,
    output logic                             status_clr_out
);
    import cmr_pkg::*;
    initial begin
        cnt_up_out = 1'b0;
        cnt_down_out = 1'b0;
        gate_set_out = 1'b0;
        gate_clr_out = 1'b0;
        status_clr_out = 1'b0;
    end
    // parameters change at once; callers stand on a falling edge
    task automatic cfg(input cmr_mode_t m, input cmr_dir_t d,
            input logic signed [CNT_W-1:0] ld, input logic signed [CNT_W-1:0] ev,
            input logic c);
        mode_out        = m;
        dir_out         = d;
        load_value_out  = ld;
        end_value_out   = ev;
        cancel_mode_out = c;
    endtask : cfg
    task automatic gates(input logic a, input logic he, input logic h);
        alarm_en_out   = a;
        hw_gate_en_out = he;
        hw_gate_out    = h;
    endtask : gates
    // control word: 0 gate set, 1 gate clear, 2 status clear; high one cycle
    task automatic ctl(input int k);
        @(negedge ref_clk_in);
        gate_set_out   = (k == 0);
        gate_clr_out   = (k == 1);
        status_clr_out = (k == 2);
        @(negedge ref_clk_in);
        gate_set_out   = 1'b0;
        gate_clr_out   = 1'b0;
        status_clr_out = 1'b0;
    endtask : ctl
    // high for one cycle, never both at once
    task automatic pulse(input logic up);
        @(negedge ref_clk_in);
        cnt_up_out = up;
        cnt_down_out = !up;
        @(negedge ref_clk_in);
        cnt_up_out = 1'b0;
        cnt_down_out = 1'b0;
    endtask : pulse
endmodule : cmr_enc_model
`default_nettype wire

// ---- dv/cmr_core_tb_top.sv ----
// testbench for the count-mode core: mode sequences with expected values
// assumes the encoder and host model drives every input but clock and reset
`timescale 1ns/10ps
`default_nettype none
module cmr_core_tb_top;
    import cmr_pkg::*;
    logic clk, rst_n, up, dn, cancel, alarm_en, hw_en, hw, g_set, g_clr, s_clr;
    cmr_mode_t mode;
    cmr_dir_t dir;
    logic signed [31:0] load, endv, count;
    logic sw_gate, ov, un, endr, alarm;
    int fails = 0;
    int n_compared = 0;
    cmr_enc_model u_enc (.ref_clk_in(clk), .cnt_up_out(up), .cnt_down_out(dn),
        .mode_out(mode), .dir_out(dir), .cancel_mode_out(cancel), .alarm_en_out(alarm_en),
        .hw_gate_en_out(hw_en), .hw_gate_out(hw), .load_value_out(load),
        .end_value_out(endv), .gate_set_out(g_set), .gate_clr_out(g_clr),
        .status_clr_out(s_clr));
    cmr_core DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .cnt_up_in(up), .cnt_down_in(dn),
        .mode_in(mode), .dir_in(dir), .cancel_mode_in(cancel), .alarm_en_in(alarm_en),
        .hw_gate_en_in(hw_en), .hw_gate_in(hw), .load_value_in(load),
        .end_value_in(endv), .gate_set_in(g_set), .gate_clr_in(g_clr),
        .status_clr_in(s_clr), .count_out(count), .sw_gate_out(sw_gate),
        .overflow_out(ov), .underflow_out(un), .end_reached_out(endr),
        .alarm_req_out(alarm));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // flags order: gate, overflow, underflow, end value, alarm
    task automatic st(input logic [31:0] c, input logic [4:0] f);
        chk("count", c, count);
        chk("flags", {27'h0, f}, {27'h0, sw_gate, ov, un, endr, alarm});
    endtask : st
    // about thirty-five times the expected run
    initial begin
        #200us;
        fails++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        u_enc.cfg(CMR_ENDLESS, CMR_DIR_NONE, CMR_UPPER - CMR_ONE, CMR_ZERO, 1'b0);
        u_enc.gates(1'b1, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        st(CMR_ZERO, 5'h00);
        u_enc.ctl(0);
        st(CMR_UPPER - CMR_ONE, 5'h10);
        u_enc.pulse(1'b1);
        st(CMR_UPPER, 5'h10);
        u_enc.pulse(1'b1);
        st(CMR_LOWER, 5'h19);
        u_enc.gates(1'b0, 1'b0, 1'b1);
        u_enc.pulse(1'b0);
        st(CMR_UPPER, 5'h1c);
        u_enc.gates(1'b1, 1'b0, 1'b1);
        u_enc.ctl(2);
        st(CMR_UPPER, 5'h10);
        u_enc.gates(1'b1, 1'b1, 1'b0);
        u_enc.pulse(1'b1);
        st(CMR_UPPER, 5'h10);
        u_enc.gates(1'b1, 1'b1, 1'b1);
        u_enc.pulse(1'b1);
        st(CMR_LOWER, 5'h19);
        u_enc.ctl(2);
        st(CMR_LOWER, 5'h10);
        u_enc.gates(1'b1, 1'b0, 1'b1);
        u_enc.cfg(CMR_ONE_TIME, CMR_DIR_UP, 32'sh00000008, 32'sh0000000a, 1'b0);
        u_enc.ctl(1);
        u_enc.pulse(1'b1);
        st(CMR_LOWER, 5'h00);
        u_enc.ctl(0);
        st(32'sh00000008, 5'h10);
        u_enc.pulse(1'b1);
        st(32'sh00000009, 5'h10);
        u_enc.pulse(1'b1);
        st(32'sh00000008, 5'h03);
        u_enc.ctl(0);
        st(32'sh00000008, 5'h12);
        u_enc.ctl(2);
        u_enc.ctl(1);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_DOWN, 32'shfffffffd, 32'shfffffffb, 1'b0);
        u_enc.ctl(0);
        st(32'shfffffffd, 5'h10);
        u_enc.pulse(1'b0);
        st(32'shfffffffc, 5'h10);
        u_enc.pulse(1'b0);
        st(32'shfffffffd, 5'h13);
        u_enc.ctl(1);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_DOWN, CMR_UPPER, 32'shfffffffb, 1'b0);
        u_enc.ctl(0);
        st(CMR_UPPER, 5'h12);
        u_enc.pulse(1'b1);
        st(CMR_LOWER, 5'h1b);
        u_enc.ctl(2);
        u_enc.ctl(1);
        u_enc.cfg(CMR_ONE_TIME, CMR_DIR_NONE, CMR_UPPER, 32'shfffffffb, 1'b1);
        u_enc.ctl(0);
        st(CMR_UPPER, 5'h10);
        u_enc.cfg(CMR_ONE_TIME, CMR_DIR_NONE, CMR_UPPER, 32'shfffffffb, 1'b0);
        u_enc.pulse(1'b1);
        st(CMR_LOWER, 5'h09);
        u_enc.ctl(0);
        st(CMR_LOWER, 5'h18);
        u_enc.pulse(1'b0);
        st(CMR_UPPER, 5'h0d);
        u_enc.ctl(1);
        u_enc.ctl(2);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_NONE, CMR_UPPER, 32'shfffffffb, 1'b1);
        u_enc.ctl(0);
        st(CMR_UPPER, 5'h10);
        u_enc.pulse(1'b1);
        st(CMR_UPPER, 5'h19);
        u_enc.ctl(2);
        u_enc.ctl(1);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_NONE, CMR_LOWER, 32'shfffffffb, 1'b1);
        u_enc.ctl(0);
        st(CMR_LOWER, 5'h10);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_NONE, 32'sh00000005, 32'shfffffffb, 1'b1);
        u_enc.pulse(1'b0);
        st(32'sh00000005, 5'h15);
        u_enc.ctl(1);
        u_enc.ctl(2);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_UP, 32'sh00000003, 32'sh00000005, 1'b0);
        u_enc.ctl(0);
        st(32'sh00000003, 5'h10);
        u_enc.pulse(1'b1);
        st(32'sh00000004, 5'h10);
        u_enc.pulse(1'b1);
        st(32'sh00000003, 5'h13);
        u_enc.ctl(1);
        u_enc.cfg(CMR_PERIODIC, CMR_DIR_UP, CMR_LOWER, 32'sh00000005, 1'b0);
        u_enc.ctl(2);
        u_enc.ctl(0);
        st(CMR_LOWER, 5'h10);
        u_enc.pulse(1'b0);
        st(CMR_UPPER, 5'h15);
        u_enc.ctl(1);
        u_enc.ctl(2);
        u_enc.cfg(CMR_ONE_TIME, CMR_DIR_DOWN, 32'shfffffffd, 32'shfffffffb, 1'b0);
        u_enc.ctl(0);
        st(32'shfffffffd, 5'h10);
        u_enc.pulse(1'b0);
        st(32'shfffffffc, 5'h10);
        u_enc.pulse(1'b0);
        st(32'shfffffffd, 5'h03);
        u_enc.ctl(0);
        st(32'shfffffffd, 5'h12);
        // second reset in mid-run: everything back to idle, first open loads
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        st(CMR_ZERO, 5'h00);
        u_enc.ctl(0);
        st(32'shfffffffd, 5'h10);
        u_enc.pulse(1'b0);
        st(32'shfffffffc, 5'h10);
        stop_test();
    end
endmodule : cmr_core_tb_top
`default_nettype wire
